// file: include/nibble_cpu_defines.svh
// Opcode values, field masks and fixed constants of the nibble core.
// Assumes inclusion by bare name from the decoder and core design modules.
`ifndef NIBBLE_CPU_DEFINES_SVH
`define NIBBLE_CPU_DEFINES_SVH

// ----------------------------------------
// Single-byte opcodes
// ----------------------------------------
`define OP_CLEAR_ACC 8'hE0
`define OP_CLEAR_CARRY 8'hE1
`define OP_SET_CARRY 8'hF1
`define OP_INVERT_ACC 8'hEB
`define OP_INC_ACC 8'h0E
`define OP_DEC_ACC 8'h0F
`define OP_ROTATE_LEFT 8'h01
`define OP_COPY_TO_AUX 8'h03
`define OP_SWAP_AUX 8'h0D
`define OP_INC_MEM 8'h2E
`define OP_DEC_MEM 8'h2F
`define OP_ADD_MEM 8'h60
`define OP_ADD_MEM_CARRY 8'h20
`define OP_BCD_ADD_FIX 8'hE6
`define OP_BCD_SUB_FIX 8'hEA
`define OP_XOR_MEM 8'hF5
`define OP_AND_MEM 8'hE7
`define OP_OR_MEM 8'hE5
`define OP_COMPARE_MEM 8'hFB
`define OP_COMPARE_PREFIX 8'h2C
`define OP_STORE_MEM 8'h02
`define OP_LOAD_MEM 8'h21
`define OP_SWAP_INC 8'hFE
`define OP_SWAP_DEC 8'hFF
`define OP_TABLE_READ 8'h63

// ----------------------------------------
// Opcodes carrying a field, with masks
// ----------------------------------------
`define OP_SET_MEM_BIT 8'h08
`define OP_CLR_MEM_BIT 8'h28
`define MASK_BIT_OP 8'hFC
`define OP_LOAD_IMM 8'hC0
`define MASK_LOAD_IMM 8'hF0
`define OP_SWAP_MODIFY 8'hA0
`define MASK_SWAP_MODIFY 8'hF8

// ----------------------------------------
// Second byte selectors and constants
// ----------------------------------------
`define SEL_COMPARE_IMM 4'h4
`define SEL_COMPARE_LOW 4'h0
`define BCD_ADD_FIX 4'h6
`define BCD_SUB_FIX 4'hA
`define NIBBLE_ONE 4'h1
`define NIBBLE_ALL 4'hF
`define NIBBLE_ZERO 4'h0

`endif

// file: include/nibble_cpu_pkg.sv
// Types shared by the nibble core and its opcode decoder.
// Assumes the defines header is on the include path.
package nibble_cpu_pkg;

   typedef enum logic [1:0] {
      phase_fetch,
      phase_imm,
      phase_stall,
      phase_table
   } phase_type;

   typedef enum logic [4:0] {
      op_nop, op_clear_acc, op_clear_carry, op_set_carry, op_invert,
      op_inc_acc, op_dec_acc, op_rotate, op_copy_aux, op_swap_aux,
      op_inc_mem, op_dec_mem, op_set_bit, op_clr_bit, op_add,
      op_add_carry, op_bcd_add, op_bcd_sub, op_xor, op_and,
      op_or, op_cmp_mem, op_cmp_prefix, op_load_imm, op_store,
      op_load, op_swap_modify, op_swap_inc, op_swap_dec, op_table
   } op_type;

   typedef struct packed {
      phase_type phase;
      logic [3:0] work_nibble;
      logic [3:0] aux_nibble;
      logic carry_flag;
      logic zero_flag;
      logic [3:0] pointer_high;
      logic [3:0] pointer_low;
      logic run_nop;
      logic mem_we;
      logic [7:0] mem_waddr;
      logic [3:0] mem_wdata;
   } core_state_type;

endpackage : nibble_cpu_pkg

// file: hdl/nibble_op_decode.sv
// Opcode decoder: maps a fetched byte to an operation class.
// Assumes the byte is stable while the core samples it.
`timescale 1ns/1ps
`include "nibble_cpu_defines.svh"

module nibble_op_decode
   import nibble_cpu_pkg::*;
(
   // Fetched byte
   input wire logic [7:0] op_byte,
   // Operation class
   output op_type op_class
);

   always_comb begin
      op_class = op_nop;
      case (op_byte)
         `OP_CLEAR_ACC: op_class = op_clear_acc;
         `OP_CLEAR_CARRY: op_class = op_clear_carry;
         `OP_SET_CARRY: op_class = op_set_carry;
         `OP_INVERT_ACC: op_class = op_invert;
         `OP_INC_ACC: op_class = op_inc_acc;
         `OP_DEC_ACC: op_class = op_dec_acc;
         `OP_ROTATE_LEFT: op_class = op_rotate;
         `OP_COPY_TO_AUX: op_class = op_copy_aux;
         `OP_SWAP_AUX: op_class = op_swap_aux;
         `OP_INC_MEM: op_class = op_inc_mem;
         `OP_DEC_MEM: op_class = op_dec_mem;
         `OP_ADD_MEM: op_class = op_add;
         `OP_ADD_MEM_CARRY: op_class = op_add_carry;
         `OP_BCD_ADD_FIX: op_class = op_bcd_add;
         `OP_BCD_SUB_FIX: op_class = op_bcd_sub;
         `OP_XOR_MEM: op_class = op_xor;
         `OP_AND_MEM: op_class = op_and;
         `OP_OR_MEM: op_class = op_or;
         `OP_COMPARE_MEM: op_class = op_cmp_mem;
         `OP_COMPARE_PREFIX: op_class = op_cmp_prefix;
         `OP_STORE_MEM: op_class = op_store;
         `OP_LOAD_MEM: op_class = op_load;
         `OP_SWAP_INC: op_class = op_swap_inc;
         `OP_SWAP_DEC: op_class = op_swap_dec;
         `OP_TABLE_READ: op_class = op_table;
         default: begin
            if ((op_byte & `MASK_BIT_OP) == `OP_SET_MEM_BIT) begin
               op_class = op_set_bit;
            end else if ((op_byte & `MASK_BIT_OP) == `OP_CLR_MEM_BIT) begin
               op_class = op_clr_bit;
            end else if ((op_byte & `MASK_LOAD_IMM) == `OP_LOAD_IMM) begin
               op_class = op_load_imm;
            end else if ((op_byte & `MASK_SWAP_MODIFY) == `OP_SWAP_MODIFY) begin
               op_class = op_swap_modify;
            end
         end
      endcase
   end

endmodule : nibble_op_decode

// file: hdl/nibble_alu_core.sv
// Decode and execute of accumulator, memory, arithmetic, compare and
// load/store instructions. Assumes an asynchronous-read nibble RAM and
// a table ROM whose byte answers one cycle after the address.
`timescale 1ns/1ps
`include "nibble_cpu_defines.svh"

// Overview of operation
// - Clear sets work nibble zero, updates zero
// - Rotate left through carry, zero updated
// - BCD add fix adds 6, carry kept
// - BCD subtract fix adds 10, one cycle
// - XOR/AND/OR with memory into work nibble
// - Compare memory sets carry and zero only
// - Compare immediate: two bytes, carry and zero
// - Compare pointer low: XOR, zero only
// - Load immediate from opcode low nibble
// - Swap memory, XOR pointer high, two cycles
// - Swap-modify zero from pointer high comparison
// - Plain swap, zero from pointer high
// - Swap then increment pointer low, zero
// - Swap then decrement pointer low, zero
// - Table read loads work and auxiliary nibbles
// - Load/clear run: followers become no-ops
// - Memory compare flag table
// - Immediate compare flag table
module nibble_alu_core
   import nibble_cpu_pkg::*;
#(
   parameter int ram_addr_w = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Instruction byte stream
   input wire logic instr_valid,
   input wire logic [7:0] instr_byte,
   output logic instr_ready,
   // Data RAM
   output logic [ram_addr_w-1:0] ram_addr,
   input wire logic [3:0] ram_rdata,
   output logic ram_we,
   output logic [ram_addr_w-1:0] ram_waddr,
   output logic [3:0] ram_wdata,
   // Table ROM
   output logic [7:0] table_addr,
   input wire logic [7:0] table_data,
   // Visible state
   output logic [3:0] work_nibble,
   output logic [3:0] aux_nibble,
   output logic carry_flag,
   output logic zero_flag,
   output logic [3:0] pointer_high,
   output logic [3:0] pointer_low
);

   // ----------------------------------------
   // Parameter check
   // ----------------------------------------
   if (ram_addr_w < 1 || ram_addr_w > 8) begin : g_bad_width
      $error("ram_addr_w must be 1 to 8");
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [4:0] add4(input logic [3:0] a, input logic [3:0] b,
                                       input logic cin);
      return {1'b0, a} + {1'b0, b} + {4'h0, cin};
   endfunction : add4

   function automatic logic [3:0] bit_mask(input logic [1:0] sel);
      return 4'h1 << sel;
   endfunction : bit_mask

   core_state_type s_q;
   core_state_type s_d;
   op_type op;
   logic [7:0] pointer;
   logic [3:0] mem_val;
   logic [4:0] sum;
   logic [3:0] res;

   nibble_op_decode u_decode (
      .op_byte(instr_byte),
      .op_class(op)
   );

   assign pointer = {s_q.pointer_high, s_q.pointer_low};
   // Forward a pending write so back-to-back memory ops see fresh data
   assign mem_val = (s_q.mem_we && s_q.mem_waddr == pointer) ? s_q.mem_wdata : ram_rdata;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.mem_we = 1'b0;
      sum = 5'h00;
      res = `NIBBLE_ZERO;
      case (s_q.phase)
         phase_fetch: begin
            if (instr_valid) begin
               s_d.run_nop = 1'b0;
               case (op)
                  op_clear_acc, op_load_imm: begin
                     s_d.run_nop = 1'b1;
                     if (!s_q.run_nop) begin
                        res = (op == op_clear_acc) ? `NIBBLE_ZERO : instr_byte[3:0];
                        s_d.work_nibble = res;
                        s_d.zero_flag = (res == `NIBBLE_ZERO);
                     end
                  end
                  op_clear_carry: s_d.carry_flag = 1'b0;
                  op_set_carry: s_d.carry_flag = 1'b1;
                  op_invert: begin
                     res = ~s_q.work_nibble;
                     s_d.work_nibble = res;
                     s_d.zero_flag = (res == `NIBBLE_ZERO);
                  end
                  op_inc_acc, op_dec_acc, op_inc_mem, op_dec_mem: begin
                     res = (op == op_inc_acc || op == op_dec_acc) ? s_q.work_nibble : mem_val;
                     if (op == op_inc_acc || op == op_inc_mem) begin
                        sum = add4(res, `NIBBLE_ONE, 1'b0);
                        s_d.carry_flag = sum[4];
                     end else begin
                        sum = add4(res, `NIBBLE_ALL, 1'b0);
                        s_d.carry_flag = ~sum[4];
                     end
                     s_d.zero_flag = (sum[3:0] == `NIBBLE_ZERO);
                     if (op == op_inc_acc || op == op_dec_acc) begin
                        s_d.work_nibble = sum[3:0];
                     end else begin
                        s_d.mem_we = 1'b1;
                        s_d.mem_waddr = pointer;
                        s_d.mem_wdata = sum[3:0];
                     end
                  end
                  op_rotate: begin
                     res = {s_q.work_nibble[2:0], s_q.carry_flag};
                     s_d.work_nibble = res;
                     s_d.carry_flag = s_q.work_nibble[3];
                     s_d.zero_flag = (res == `NIBBLE_ZERO);
                  end
                  op_copy_aux: s_d.aux_nibble = s_q.work_nibble;
                  op_swap_aux: begin
                     s_d.aux_nibble = s_q.work_nibble;
                     s_d.work_nibble = s_q.aux_nibble;
                  end
                  op_set_bit, op_clr_bit: begin
                     res = (op == op_set_bit) ? (mem_val | bit_mask(instr_byte[1:0])) :
                           (mem_val & ~bit_mask(instr_byte[1:0]));
                     s_d.mem_we = 1'b1;
                     s_d.mem_waddr = pointer;
                     s_d.mem_wdata = res;
                     if (op == op_clr_bit) begin
                        s_d.zero_flag = (res == `NIBBLE_ZERO);
                     end
                  end
                  op_add, op_add_carry: begin
                     sum = add4(s_q.work_nibble, mem_val, (op == op_add_carry) & s_q.carry_flag);
                     s_d.work_nibble = sum[3:0];
                     s_d.carry_flag = sum[4];
                     s_d.zero_flag = (sum[3:0] == `NIBBLE_ZERO);
                  end
                  op_bcd_add, op_bcd_sub: begin
                     sum = add4(s_q.work_nibble,
                                (op == op_bcd_add) ? `BCD_ADD_FIX : `BCD_SUB_FIX, 1'b0);
                     s_d.work_nibble = sum[3:0];
                     s_d.zero_flag = (sum[3:0] == `NIBBLE_ZERO);
                  end
                  op_xor, op_and, op_or: begin
                     res = (op == op_xor) ? (s_q.work_nibble ^ mem_val) :
                           (op == op_and) ? (s_q.work_nibble & mem_val) :
                           (s_q.work_nibble | mem_val);
                     s_d.work_nibble = res;
                     s_d.zero_flag = (res == `NIBBLE_ZERO);
                  end
                  op_cmp_mem: begin
                     sum = add4(s_q.work_nibble, ~mem_val, 1'b1);
                     s_d.carry_flag = sum[4];
                     s_d.zero_flag = (sum[3:0] == `NIBBLE_ZERO);
                  end
                  op_cmp_prefix: s_d.phase = phase_imm;
                  op_store: begin
                     s_d.mem_we = 1'b1;
                     s_d.mem_waddr = pointer;
                     s_d.mem_wdata = s_q.work_nibble;
                  end
                  op_load: begin
                     s_d.work_nibble = mem_val;
                     s_d.zero_flag = (mem_val == `NIBBLE_ZERO);
                  end
                  op_swap_modify, op_swap_inc, op_swap_dec: begin
                     s_d.work_nibble = mem_val;
                     s_d.mem_we = 1'b1;
                     s_d.mem_waddr = pointer;
                     s_d.mem_wdata = s_q.work_nibble;
                     s_d.phase = phase_stall;
                     if (op == op_swap_modify) begin
                        res = {1'b0, instr_byte[2:0]};
                        s_d.pointer_high = s_q.pointer_high ^ res;
                        s_d.zero_flag = (s_q.pointer_high == res);
                     end else begin
                        res = (op == op_swap_inc) ? s_q.pointer_low + `NIBBLE_ONE :
                              s_q.pointer_low - `NIBBLE_ONE;
                        s_d.pointer_low = res;
                        s_d.zero_flag = (res == `NIBBLE_ZERO);
                     end
                  end
                  op_table: s_d.phase = phase_table;
                  default: ;
               endcase
            end
         end
         phase_imm: begin
            if (instr_valid) begin
               s_d.phase = phase_fetch;
               if (instr_byte[7:4] == `SEL_COMPARE_IMM) begin
                  sum = add4(s_q.work_nibble, ~instr_byte[3:0], 1'b1);
                  s_d.carry_flag = sum[4];
                  s_d.zero_flag = (sum[3:0] == `NIBBLE_ZERO);
               end else if (instr_byte[7:4] == `SEL_COMPARE_LOW) begin
                  s_d.zero_flag = ((s_q.pointer_low ^ instr_byte[3:0]) == `NIBBLE_ZERO);
               end
            end
         end
         phase_table: begin
            s_d.work_nibble = table_data[7:4];
            s_d.aux_nibble = table_data[3:0];
            s_d.phase = phase_fetch;
         end
         phase_stall: s_d.phase = phase_fetch;
         default: s_d.phase = phase_fetch;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign instr_ready = (s_q.phase == phase_fetch) || (s_q.phase == phase_imm);
   assign ram_addr = pointer[ram_addr_w-1:0];
   assign ram_we = s_q.mem_we;
   assign ram_waddr = s_q.mem_waddr[ram_addr_w-1:0];
   assign ram_wdata = s_q.mem_wdata;
   assign table_addr = {s_q.aux_nibble, s_q.work_nibble};
   assign work_nibble = s_q.work_nibble;
   assign aux_nibble = s_q.aux_nibble;
   assign carry_flag = s_q.carry_flag;
   assign zero_flag = s_q.zero_flag;
   assign pointer_high = s_q.pointer_high;
   assign pointer_low = s_q.pointer_low;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic take;
   assign take = (s_q.phase == phase_fetch) && instr_valid;

   AST_CLEAR: assert property (take && op == op_clear_acc && !s_q.run_nop
      |=> work_nibble == 4'h0 && zero_flag && instr_ready)
      else $error("clear did not zero the work nibble");
   AST_ROTATE: assert property (take && op == op_rotate
      |=> work_nibble == {$past(work_nibble[2:0]), $past(carry_flag)}
          && carry_flag == $past(work_nibble[3]))
      else $error("rotate left through carry wrong");
   AST_BCD_ADD: assert property (take && op == op_bcd_add
      |=> work_nibble == 4'($past(work_nibble) + 4'h6) && $stable(carry_flag))
      else $error("bcd add fix wrong");
   AST_BCD_SUB: assert property (take && op == op_bcd_sub
      |=> work_nibble == 4'($past(work_nibble) + 4'hA) && instr_ready)
      else $error("bcd subtract fix wrong");
   AST_LOAD_IMM: assert property (take && op == op_load_imm && !s_q.run_nop
      |=> work_nibble == $past(instr_byte[3:0]) && zero_flag == ($past(instr_byte[3:0]) == 4'h0))
      else $error("load immediate wrong");
   AST_RUN_NOP: assert property (take && op == op_load_imm && s_q.run_nop
      |=> $stable(work_nibble) && $stable(zero_flag))
      else $error("load in a load/clear run was not ignored");
   AST_CMP_MEM: assert property (take && op == op_cmp_mem
      |=> carry_flag == ($past(mem_val) <= $past(work_nibble))
          && zero_flag == ($past(mem_val) == $past(work_nibble)) && $stable(work_nibble))
      else $error("memory compare flags wrong");
   AST_CMP_IMM: assert property (s_q.phase == phase_imm && instr_valid
      && instr_byte[7:4] == 4'h4
      |=> carry_flag == ($past(instr_byte[3:0]) <= $past(work_nibble))
          && zero_flag == ($past(instr_byte[3:0]) == $past(work_nibble)))
      else $error("immediate compare flags wrong");
   AST_SWAP_INC: assert property (take && op == op_swap_inc
      |=> pointer_low == 4'($past(pointer_low) + 4'h1) && work_nibble == $past(mem_val)
          && !instr_ready ##1 instr_ready)
      else $error("swap with increment wrong");
   AST_SWAP_MOD: assert property (take && op == op_swap_modify
      |=> zero_flag == (pointer_high == 4'h0) && ram_we && !instr_ready)
      else $error("swap modify zero flag wrong");

   CVR_CLEAR: cover property (take && op == op_clear_acc ##1 take && op == op_load_imm);
   CVR_CMP_IMM: cover property (take && op == op_cmp_prefix ##1 instr_valid);
   CVR_SWAP_DEC: cover property (take && op == op_swap_dec ##2 take);
   CVR_TABLE: cover property (take && op == op_table ##2 instr_ready);

endmodule : nibble_alu_core

// file: tb/testbench.sv
// Self-checking bench for the nibble core: reference model, RAM and table ROM.
// Assumes the core and its decoder are compiled first, RAM width 8.
`timescale 1ns/1ps

module testbench;
   // ----------------------------------------
   // Signals and reference state
   // ----------------------------------------
   logic clk, rst, instr_valid, instr_ready, ram_we, carry_flag, zero_flag;
   logic [7:0] instr_byte, ram_addr, ram_waddr, table_addr, table_data, b, r;
   logic [3:0] ram_rdata, ram_wdata, work_nibble, aux_nibble, pointer_high, pointer_low;
   logic [3:0] ram [256];
   logic [3:0] mr [256];
   logic [3:0] w, a, ph, pl;
   logic c, z, in_run, prefix_open;
   int cyc, errors, check_count, i, k;
   typedef struct {int due; logic [3:0] w, a, ph, pl; logic c, z, r;} note_type;
   note_type notes [$];
   note_type hd;
   logic [7:0] pick [29] = '{8'hE0, 8'hC0, 8'h01, 8'hE6, 8'hEA, 8'hF5, 8'hE7, 8'hE5,
      8'hFB, 8'h2C, 8'hA0, 8'hFE, 8'hFF, 8'h63, 8'h0E, 8'h0F, 8'h2E, 8'h2F, 8'h08,
      8'h28, 8'h60, 8'h20, 8'h02, 8'h21, 8'hEB, 8'hE1, 8'hF1, 8'h03, 8'h0D};

   nibble_alu_core #(.ram_addr_w(8)) dut (.clk(clk), .rst(rst), .instr_valid(instr_valid),
      .instr_byte(instr_byte), .instr_ready(instr_ready), .ram_addr(ram_addr),
      .ram_rdata(ram_rdata), .ram_we(ram_we), .ram_waddr(ram_waddr), .ram_wdata(ram_wdata),
      .table_addr(table_addr), .table_data(table_data), .work_nibble(work_nibble),
      .aux_nibble(aux_nibble), .carry_flag(carry_flag), .zero_flag(zero_flag),
      .pointer_high(pointer_high), .pointer_low(pointer_low));

   // ----------------------------------------
   // Clock, RAM and table ROM
   // ----------------------------------------
   function automatic logic [7:0] rom_byte(input logic [7:0] ad);
      return {ad[3:0] ^ 4'h9, ad[7:4] + 4'h3};
   endfunction : rom_byte

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (ram_we) ram[ram_waddr] <= ram_wdata;
   end
   assign ram_rdata = ram[ram_addr];
   assign table_data = rom_byte(table_addr);

   // ----------------------------------------
   // Checking
   // ----------------------------------------
   task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic note(input int d, input logic rd);
      notes.push_back('{cyc + d - 1, w, a, ph, pl, c, z, rd});
   endtask : note

   always @(posedge clk) begin
      #2;
      if (notes.size() > 0 && notes[0].due == cyc) begin
         hd = notes.pop_front();
         chk("work_nibble", hd.w, work_nibble);
         chk("aux_nibble", hd.a, aux_nibble);
         chk("pointer_high", hd.ph, pointer_high);
         chk("pointer_low", hd.pl, pointer_low);
         chk("carry_flag", {3'h0, hd.c}, {3'h0, carry_flag});
         chk("zero_flag", {3'h0, hd.z}, {3'h0, zero_flag});
         chk("instr_ready", {3'h0, hd.r}, {3'h0, instr_ready});
      end
   end

   // ----------------------------------------
   // Reference model and driver
   // ----------------------------------------
   task automatic mdl(input logic [7:0] op);
      logic [7:0] ad;
      logic [3:0] m;
      logic zw, rd, ld;
      ad = {ph, pl};
      m = mr[ad];
      zw = 1'b0;
      rd = 1'b1;
      ld = (op[7:4] == 4'hC) || (op == 8'hE0);
      if (prefix_open) begin
         if (op[7:4] == 4'h4) begin
            c = (w >= op[3:0]);
            z = (w == op[3:0]);
         end else if (op[7:4] == 4'h0) z = ((pl ^ op[3:0]) == 4'h0);
      end else if (!(ld && in_run)) begin
         casez (op)
            8'hE0: begin w = 4'h0; zw = 1'b1; end
            8'hC?: begin w = op[3:0]; zw = 1'b1; end
            8'h01: begin {c, w} = {w, c}; zw = 1'b1; end
            8'hE6: begin w = w + 4'h6; zw = 1'b1; end
            8'hEA: begin w = w + 4'hA; zw = 1'b1; end
            8'hF5: begin w = w ^ m; zw = 1'b1; end
            8'hE7: begin w = w & m; zw = 1'b1; end
            8'hE5: begin w = w | m; zw = 1'b1; end
            8'hFB: begin c = (w >= m); z = (w == m); end
            8'b1010_0???: begin
               mr[ad] = w; w = m; ph = ph ^ {1'b0, op[2:0]}; z = (ph == 4'h0); rd = 1'b0;
            end
            8'hFE: begin mr[ad] = w; w = m; pl = pl + 4'h1; z = (pl == 4'h0); rd = 1'b0; end
            8'hFF: begin mr[ad] = w; w = m; pl = pl - 4'h1; z = (pl == 4'h0); rd = 1'b0; end
            8'h0E: begin {c, w} = {1'b0, w} + 5'h01; zw = 1'b1; end
            8'h0F: begin c = (w == 4'h0); w = w - 4'h1; zw = 1'b1; end
            8'h2E: begin {c, mr[ad]} = {1'b0, m} + 5'h01; z = (mr[ad] == 4'h0); end
            8'h2F: begin c = (m == 4'h0); mr[ad] = m - 4'h1; z = (mr[ad] == 4'h0); end
            8'b0000_10??: mr[ad][op[1:0]] = 1'b1;
            8'b0010_10??: begin mr[ad][op[1:0]] = 1'b0; z = (mr[ad] == 4'h0); end
            8'h60: begin {c, w} = {1'b0, w} + {1'b0, m}; zw = 1'b1; end
            8'h20: begin {c, w} = {1'b0, w} + {1'b0, m} + {4'h0, c}; zw = 1'b1; end
            8'h02: mr[ad] = w;
            8'h21: begin w = m; zw = 1'b1; end
            8'hEB: begin w = ~w; zw = 1'b1; end
            8'hE1: c = 1'b0;
            8'hF1: c = 1'b1;
            8'h03: a = w;
            8'h0D: {w, a} = {a, w};
            8'h63: begin note(1, 1'b0); {w, a} = rom_byte({a, w}); end
            default: ;
         endcase
         if (zw) z = (w == 4'h0);
      end
      if (op == 8'h63 && !prefix_open) note(2, 1'b1);
      else note(1, rd);
      in_run = ld && !prefix_open;
      prefix_open = (op == 8'h2C) && !prefix_open;
   endtask : mdl

   task automatic send(input logic [7:0] op);
      int n;
      n = 0;
      while (instr_ready !== 1'b1 && n < 8) begin
         instr_valid = 1'b0;
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 8) chk("ready_wait", 4'h1, {3'h0, instr_ready});
      instr_valid = 1'b1;
      instr_byte = op;
      @(posedge clk);
      #1;
      mdl(op);
   endtask : send

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      #400000;
      errors++;
      $display("ERROR watchdog expected done seen timeout");
      tally_and_finish;
   end

   initial begin
      k = $urandom(63);
      {rst, instr_valid, instr_byte, cyc, errors, check_count} = {1'b1, 1'b0, 8'h00, 96'h0};
      {w, a, ph, pl, c, z, in_run, prefix_open} = 20'h0;
      for (i = 0; i < 256; i++) begin
         ram[i] = 4'($urandom);
         mr[i] = ram[i];
      end
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      send(8'hC5);
      send(8'hE0);
      send(8'hC3);
      send(8'h01);
      send(8'hE0);
      for (k = 6; k < 9; k++) begin
         send(8'hE1);
         send({4'hC, 4'(k)});
         send(8'h02);
         send(8'hE1);
         send(8'hC7);
         send(8'hFB);
         send(8'h2C);
         send({4'h4, 4'(k)});
      end
      send(8'h2C);
      send({4'h0, pl});
      send(8'h2C);
      send({4'h0, ~pl});
      for (k = 0; k < 8; k++) send({5'h14, 3'(k)});
      for (k = 0; k < 17; k++) send(8'hFE);
      for (k = 0; k < 2; k++) send(8'hFF);
      for (k = 0; k < 4; k++) begin
         send({6'h02, 2'(k)});
         send({6'h0A, 2'(k)});
      end
      send(8'h00);
      send(8'hE6);
      send(8'hEA);
      send(8'hF5);
      send(8'hE7);
      send(8'hE5);
      send(8'hE1);
      send(8'hCF);
      send(8'h0E);
      send(8'h0F);
      send(8'h0F);
      send(8'h63);
      for (i = 0; i < 300; i++) begin
         b = pick[$urandom_range(28, 0)];
         r = 8'($urandom);
         if (b == 8'hC0) b = b | {4'h0, r[3:0]};
         else if (b == 8'hA0) b = b | {5'h00, r[2:0]};
         else if (b == 8'h08 || b == 8'h28) b = b | {6'h00, r[1:0]};
         send(b);
         if (b == 8'h2C) send(r[6] ? r : {1'b0, r[7], 2'b00, r[3:0]});
      end
      instr_valid = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      for (i = 0; i < 256; i++) chk("ram_word", mr[i], ram[i]);
      chk("notes_left", 4'h0, 4'(notes.size()));
      tally_and_finish;
   end
endmodule : testbench
